// ==== core/serial_port_pkg.sv ====
// Constants and types for the three-wire converter serial port.
// Assumes a single system clock; the link clock is sampled as a plain input.
package serial_port_pkg;

    localparam int RESULT_BITS  = 10;
    localparam int CTRL_BITS    = 8;
    localparam int FIFO_DEPTH   = 16;
    localparam int SYNC_STAGES  = 2;

    // Reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // Link phases
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_READ,
        PH_WRITE,
        PH_DONE
    } phase_t;

endpackage

// ==== core/result_fifo_if.sv ====
// Handshake bundle between the result FIFO and the serial port core.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface result_fifo_if #(parameter int WIDTH = 10);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source
    (
        output valid,
        output data,
        input  ready
    );
    modport sink
    (
        input  valid,
        input  data,
        output ready
    );
endinterface

// ==== core/result_fifo.sv ====
// Synchronous FIFO that buffers conversion results ahead of the serial port.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,  // System clock
    input  wire logic             rst,      // Synchronous reset
    input  wire logic             in_valid, // Write request
    output logic                  in_ready, // Room for a word
    input  wire logic [WIDTH-1:0] in_data,  // Word to store
    result_fifo_if.source         out       // Drain side
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      wr_next;
    logic [AW:0]      rd_reg;
    logic [AW:0]      rd_next;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // Status and pointer arithmetic
    // ------------------------------------------------------------
    assign empty     = (wr_reg == rd_reg);
    assign full      = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
    assign in_ready  = !full;
    assign out.valid = !empty;
    assign out.data  = mem[rd_reg[AW-1:0]];
    assign push      = in_valid && !full;
    assign pop       = out.ready && !empty;

    // Next pointers
    always_comb
    begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    // Pointer registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_reg[AW-1:0]] <= in_data;
    end
endmodule

// ==== core/three_wire_adc_serial_port.sv ====
// Slave serial port: ten-bit result reads and eight-bit control writes on one data pin.
// Assumes the link clock and direction line come from the host, sampled on sys_clk.
`timescale 1ns/10ps
module three_wire_adc_serial_port
    import serial_port_pkg::*;
#(
    parameter int RES_W = serial_port_pkg::RESULT_BITS,
    parameter int CTL_W = serial_port_pkg::CTRL_BITS,
    parameter int DEPTH = serial_port_pkg::FIFO_DEPTH
) (
    input  wire logic             sys_clk,       // System clock, 40 MHz
    input  wire logic             rst,           // Synchronous reset, active high
    input  wire logic             link_clk,      // Serial clock from host
    input  wire logic             dir,           // High read, low write
    input  wire logic             data_in,       // Data pin input side
    output logic                  data_out,      // Data pin output side
    output logic                  data_oe,       // Data pin drive enable
    input  wire logic             result_valid,  // New conversion result
    output logic                  result_ready,  // FIFO can accept result
    input  wire logic [RES_W-1:0] result_data,   // Conversion result word
    output logic [CTL_W-1:0]      ctrl_byte,     // Last control byte loaded
    output logic                  ctrl_strobe    // Pulse on control byte load
);
    import serial_port_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s1_next;
    logic [2:0] s2_next;
    logic       clk_q_reg;
    logic       dir_q_reg;
    logic       clk_q_next;
    logic       dir_q_next;
    logic       clk_s;
    logic       dir_s;
    logic       din_s;
    logic       rise;
    logic       fall;
    logic       dir_up;
    logic       dir_down;

    // Two stages on every host pin, then edge history on clock and direction
    always_comb
    begin
        s1_next    = {data_in, dir, link_clk};
        s2_next    = s1_reg;
        clk_q_next = s2_reg[0];
        dir_q_next = s2_reg[1];
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_reg    <= 3'h0;
            s2_reg    <= 3'h0;
            clk_q_reg <= 1'b0;
            dir_q_reg <= 1'b0;
        end
        else
        begin
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            clk_q_reg <= clk_q_next;
            dir_q_reg <= dir_q_next;
        end
    end

    // ------------------------------------------------------------
    // Edge helpers
    // ------------------------------------------------------------
    // One-cycle flag when a synchronised line goes low to high
    function automatic logic went_high(input logic now_v, input logic was_v);
        return now_v && !was_v;
    endfunction

    // One-cycle flag when a synchronised line goes high to low
    function automatic logic went_low(input logic now_v, input logic was_v);
        return !now_v && was_v;
    endfunction

    // Edge detection on synchronised pins; host owns the clock
    assign clk_s    = s2_reg[0];
    assign dir_s    = s2_reg[1];
    assign din_s    = s2_reg[2];
    assign rise     = went_high(clk_s, clk_q_reg);
    assign fall     = went_low(clk_s, clk_q_reg);
    assign dir_up   = went_high(dir_s, dir_q_reg);
    assign dir_down = went_low(dir_s, dir_q_reg);

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    result_fifo_if #(.WIDTH(RES_W)) fifo_bus ();

    result_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .in_valid (result_valid),
        .in_ready (result_ready),
        .in_data  (result_data),
        .out      (fifo_bus.source)
    );

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    phase_t             phase_reg;
    phase_t             phase_next;
    logic [RES_W-1:0]   shift_reg;
    logic [RES_W-1:0]   shift_next;
    logic [RES_W-1:0]   held_reg;
    logic [RES_W-1:0]   held_next;
    logic [3:0]         cnt_reg;
    logic [3:0]         cnt_next;
    logic [CTL_W-1:0]   cin_reg;
    logic [CTL_W-1:0]   cin_next;
    logic [CTL_W-1:0]   ctrl_reg;
    logic [CTL_W-1:0]   ctrl_next;
    logic               strobe_reg;
    logic               strobe_next;
    logic               oe_reg;
    logic               oe_next;
    logic               dout_reg;
    logic               dout_next;
    logic               take;

    assign fifo_bus.ready = take;

    // Next-state logic for reads and writes
    always_comb
    begin
        phase_next  = phase_reg;
        shift_next  = shift_reg;
        held_next   = held_reg;
        cnt_next    = cnt_reg;
        cin_next    = cin_reg;
        ctrl_next   = ctrl_reg;
        strobe_next = 1'b0;
        oe_next     = oe_reg;
        dout_next   = dout_reg;
        take        = 1'b0;

        // Oldest FIFO entry becomes the output result register, except during a read
        if (fifo_bus.valid && phase_reg != PH_READ)
        begin
            take      = 1'b1;
            held_next = fifo_bus.data;
        end

        if (dir_up)
        begin
            // Only a rising direction starts a read
            phase_next = PH_READ;
            shift_next = take ? fifo_bus.data : held_reg;
            dout_next  = take ? fifo_bus.data[RES_W-1] : held_reg[RES_W-1];
            oe_next    = 1'b1;
            cnt_next   = 4'h0;
        end
        else if (dir_down)
        begin
            // Falling direction releases the pin and opens a write
            phase_next = PH_WRITE;
            oe_next    = 1'b0;
            cnt_next   = 4'h0;
            cin_next   = CTRL_RESET;
        end
        else
        begin
            unique case (phase_reg)
                PH_READ:
                begin
                    // First fall is skipped, the next nine falls shift, later falls are ignored
                    if (fall)
                    begin
                        if (cnt_reg == 4'h0)
                            cnt_next = 4'h1;
                        else if (cnt_reg < 4'(RES_W))
                        begin
                            shift_next = {shift_reg[RES_W-2:0], 1'b0};
                            dout_next  = shift_reg[RES_W-2];
                            cnt_next   = cnt_reg + 4'h1;
                        end
                    end
                end
                PH_WRITE:
                begin
                    // Eight bits on rising edges, then ignore
                    if (rise)
                    begin
                        cin_next = {cin_reg[CTL_W-2:0], din_s};
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == 4'(CTL_W - 1))
                        begin
                            ctrl_next   = {cin_reg[CTL_W-2:0], din_s};
                            strobe_next = 1'b1;
                            phase_next  = PH_DONE;
                        end
                    end
                end
                PH_DONE:
                begin
                    phase_next = PH_DONE;
                end
                PH_IDLE:
                begin
                    phase_next = PH_IDLE;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            phase_reg  <= PH_IDLE;
            shift_reg  <= RESULT_RESET;
            held_reg   <= RESULT_RESET;
            cnt_reg    <= 4'h0;
            cin_reg    <= CTRL_RESET;
            ctrl_reg   <= CTRL_RESET;
            strobe_reg <= 1'b0;
            oe_reg     <= 1'b0;
            dout_reg   <= 1'b0;
        end
        else
        begin
            phase_reg  <= phase_next;
            shift_reg  <= shift_next;
            held_reg   <= held_next;
            cnt_reg    <= cnt_next;
            cin_reg    <= cin_next;
            ctrl_reg   <= ctrl_next;
            strobe_reg <= strobe_next;
            oe_reg     <= oe_next;
            dout_reg   <= dout_next;
        end
    end

    // Outputs from flip-flops
    assign data_out    = dout_reg;
    assign data_oe     = oe_reg;
    assign ctrl_byte   = ctrl_reg;
    assign ctrl_strobe = strobe_reg;
endmodule

// ==== test/three_wire_adc_serial_port_chk.sv ====
// Pin-level checker for the serial port.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/10ps
module serial_port_chk #(
    parameter int CTL_W = 8
) (
    input wire logic             sys_clk,    // Clock
    input wire logic             rst,        // Reset
    input wire logic             dir,        // Direction
    input wire logic             data_oe,    // Pin enable
    input wire logic [CTL_W-1:0] ctrl_byte,  // Control byte
    input wire logic             ctrl_strobe // Load pulse
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence read_start; $rose(dir); endsequence
    sequence write_start; $fell(dir); endsequence
    a_oe_on_read: assert property (read_start |-> ##[2:5] data_oe)
        else $error("pin not driven after read start");
    a_oe_off_write: assert property (write_start |-> ##[2:5] !data_oe)
        else $error("pin not released after read end");
    a_oe_held: assert property (data_oe && dir |=> data_oe)
        else $error("pin dropped during read");
    a_oe_idle: assert property (!dir [*8] |-> !data_oe)
        else $error("pin driven while writing");
    a_strobe_once: assert property (ctrl_strobe |=> !ctrl_strobe [*8])
        else $error("control load repeated");
    a_strobe_write: assert property (ctrl_strobe |-> !dir && !data_oe)
        else $error("control load outside write");
    a_ctrl_loads: assert property ($changed(ctrl_byte) |-> ctrl_strobe)
        else $error("control byte changed without load");
    a_reset_state: assert property ($fell(rst) |-> !data_oe && ctrl_byte == '0)
        else $error("bad state after reset");
endmodule
bind three_wire_adc_serial_port serial_port_chk #(.CTL_W(CTL_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .dir(dir), .data_oe(data_oe),
    .ctrl_byte(ctrl_byte), .ctrl_strobe(ctrl_strobe));

// ==== test/host_model.sv ====
// Host model: drives serial clock, direction and host data.
// Assumes the bench resolves the shared pin and feeds it back.
`timescale 1ns/10ps
module host_model (
    input  wire logic sys_clk,  // System clock
    input  wire logic pin,      // Resolved data pin
    output logic      link_clk, // Serial clock, idles high
    output logic      dir,      // Direction
    output logic      host_d,   // Host data
    output logic      host_oe   // Host drives pin
);
    // -----
    // Tasks
    // -----
    initial
    begin
        link_clk = 1'b1;
        dir      = 1'b0;
        host_d   = 1'b0;
        host_oe  = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic set_dir(input logic v);
        @(posedge sys_clk) dir <= v;
        idle(8);
    endtask
    // One clock; hp sets speed, sample late in high phase
    task automatic pulse(input int hp, output logic s);
        @(posedge sys_clk) link_clk <= 1'b0;
        idle(hp);
        @(posedge sys_clk) link_clk <= 1'b1;
        idle(hp);
        s = pin;
    endtask
    task automatic rd_xfer(input int n, input int hp, input bit fresh,
                           output logic [9:0] v);
        logic s;
        v = 10'h000;
        if (fresh)
        begin
            set_dir(1'b0);
            set_dir(1'b1);
        end
        for (int i = 0; i < n; i++)
        begin
            pulse(hp, s);
            v = {v[8:0], s};
        end
    endtask
    task automatic wr_xfer(input logic [15:0] w, input int n, input bit fresh);
        logic s;
        if (fresh)
        begin
            set_dir(1'b1);
            set_dir(1'b0);
        end
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            host_oe <= 1'b1;
            host_d  <= w[15-i];
            pulse(4, s);
        end
        host_oe <= 1'b0;
    endtask
endmodule

// ==== test/three_wire_adc_serial_port_bench.sv ====
// Bench for the serial port: reset, reads, writes, FIFO fill.
// Assumes host_model and the bound checker.
`timescale 1ns/10ps
module three_wire_adc_serial_port_bench;
    import serial_port_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst;
    logic       float_reg = 1'b0;
    logic       result_valid;
    logic [9:0] result_data;
    logic       link_clk, dir, host_d, host_oe, pin, data_out, data_oe;
    logic       result_ready, ctrl_strobe;
    logic [7:0] ctrl_byte;
    int         mismatches = 0, checks_done = 0, strobes = 0, cycles = 0;
    // ---------------
    // Clock and parts
    // ---------------
    always #12.5 sys_clk = ~sys_clk;
    // Undriven pin toggles; count strobes and cycles
    always @(posedge sys_clk)
    begin
        float_reg <= ~float_reg;
        strobes   <= strobes + int'(ctrl_strobe === 1'b1);
        cycles    <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            test_done();
        end
    end
    assign pin = data_oe ? data_out : (host_oe ? host_d : float_reg);
    three_wire_adc_serial_port dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .dir(dir), .data_in(pin), .data_out(data_out), .data_oe(data_oe),
        .result_valid(result_valid), .result_ready(result_ready),
        .result_data(result_data), .ctrl_byte(ctrl_byte), .ctrl_strobe(ctrl_strobe));
    host_model host (.sys_clk(sys_clk), .pin(pin), .link_clk(link_clk), .dir(dir),
        .host_d(host_d), .host_oe(host_oe));
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        checks_done++;
        if (seen !== want)
        begin
            mismatches++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic push(input logic [9:0] w, output logic took);
        @(posedge sys_clk);
        result_valid <= 1'b1;
        result_data  <= w;
        @(posedge sys_clk);
        took = result_ready;
        result_valid <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ---------
    // Scenarios
    // ---------
    task automatic t_read();
        logic t;
        logic [9:0] a, b, c;
        check(data_oe, 1'b0);
        check(10'(ctrl_byte), 10'(CTRL_RESET));
        push(10'h1c3, t);
        host.idle(20);
        host.rd_xfer(8, 6, 1'b1, a);
        check(a, 10'h070);
        host.rd_xfer(2, 4, 1'b0, b);
        check(b, 10'h003);
        host.rd_xfer(1, 4, 1'b0, c);
        check(c, 10'h001);
        host.set_dir(1'b0);
        check(data_oe, 1'b0);
        $display("read test done");
    endtask
    task automatic t_write();
        int s0;
        s0 = strobes;
        host.wr_xfer(16'hb4ff, 10, 1'b1);
        host.idle(8);
        check(10'(ctrl_byte), 10'h0b4);
        host.wr_xfer(16'h3c00, 8, 1'b0);
        host.idle(8);
        check(10'(ctrl_byte), 10'h0b4);
        host.wr_xfer(16'h5a00, 8, 1'b1);
        host.idle(8);
        check(10'(ctrl_byte), 10'h05a);
        check(10'(strobes - s0), 10'h002);
        $display("write test done");
    endtask
    task automatic t_fifo();
        logic t;
        logic [9:0] v;
        int n;
        n = 0;
        host.set_dir(1'b1);
        for (int i = 0; i < 17; i++)
        begin
            push(10'h100 + 10'(i), t);
            n += int'(t === 1'b1);
        end
        check(10'(n), 10'h010);
        host.set_dir(1'b0);
        host.idle(40);
        check(result_ready, 1'b1);
        host.rd_xfer(10, 4, 1'b1, v);
        check(v, 10'h10f);
        $display("fifo test done");
    endtask
    initial
    begin
        rst          = 1'b1;
        result_valid = 1'b0;
        result_data  = 10'h000;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_read();
        t_write();
        t_fifo();
        test_done();
    end
endmodule
